// file: rtl/fss_regs.svh
// register offsets, field positions and reset values of the slot framer
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_OFS_SLOT_CFG  12'h000
`define FSS_OFS_STATUS    12'h004
`define FSS_OFS_IRQ_STAT  12'h008
`define FSS_OFS_IRQ_EN    12'h00C
`define FSS_OFS_IRQ_CLR   12'h010
`define FSS_OFS_NV_COUNT  12'h014
`define FSS_OFS_CTRL_BYTE 12'h018
`define FSS_OFS_FRAME_LEN 12'h01C
`define FSS_SLOT_CFG_RST  32'h0000_0000
`define FSS_IRQ_EN_RST    4'h0
`define FSS_IRQ_CFG       0
`define FSS_IRQ_CTRL      1
`define FSS_IRQ_NVWR      2
`define FSS_IRQ_NVLIM     3
`define FSS_REC_BYTES     5
`define FSS_CTRL_BYTES    1
`define FSS_SAP_CLASS1    8'h33
`define FSS_NV_LIMIT      32'd1000000
`endif

// file: rtl/fss_pkg.sv
// types shared by the slot status framer
`default_nettype none
package fss_pkg;
    typedef enum logic [1:0] {
        FSS_SLOT_EMPTY = 2'h0,
        FSS_SLOT_AI = 2'h1,
        FSS_SLOT_TOT = 2'h2,
        FSS_SLOT_CTRL = 2'h3
    } fss_slot_t;
    typedef enum logic [1:0] {
        FSS_OK = 2'h0,
        FSS_LOW = 2'h1,
        FSS_HIGH = 2'h2,
        FSS_CONST = 2'h3
    } fss_limit_t;
    typedef enum logic [3:0] {
        FSS_Q_GOOD_OK = 4'h0,
        FSS_Q_GOOD_PARAM = 4'h1,
        FSS_Q_GOOD_WARN = 4'h2,
        FSS_Q_GOOD_ALARM = 4'h3,
        FSS_Q_UNC = 4'h4,
        FSS_Q_UNC_LAST = 4'h5,
        FSS_Q_UNC_SUBST = 4'h6,
        FSS_Q_UNC_NOSAVE = 4'h7,
        FSS_Q_UNC_INACC = 4'h8,
        FSS_Q_UNC_MANUAL = 4'h9,
        FSS_Q_BAD_NOFB = 4'hA,
        FSS_Q_BAD_DEV = 4'hB,
        FSS_Q_BAD_SENSOR = 4'hC,
        FSS_Q_BAD_NOCOMM = 4'hD,
        FSS_Q_BAD_OOS = 4'hE
    } fss_qual_t;
    // framer walk, gray coded along idle -> run -> done
    typedef enum logic [1:0] {
        FSS_ST_IDLE = 2'b00,
        FSS_ST_RUN = 2'b01,
        FSS_ST_DONE = 2'b11
    } fss_state_t;
endpackage
`default_nettype wire

// file: rtl/fss_framer.sv
// cyclic slot framer with status encoding, acyclic access and nv guard
//
// Behaviour
// - nine slots in fixed documented order
// - analog input slot sends five bytes only
// - plain totalizer sends five bytes, no outputs
// - control slot takes one output byte
// - empty slots zero bytes; trailing slots omitted
// - status low two bits carry limit; code leaves them clear for no comm, and for sensor with constant limit
// - bad quality base codes as listed
// - uncertain generic, last, substitute base codes
// - uncertain not saved, inaccurate, manual codes
// - good quality base codes as listed
// - acyclic access during cyclic exchange
// - acyclic access by slot and index
// - two class 2 service access points
// - class 1 acyclic on access point 33h
// - acyclic writes committed to nv store
`include "fss_regs.svh"
`default_nettype none
module fss_framer #(
    parameter int NSLOT = 9,
    parameter logic [31:0] NV_LIMIT = `FSS_NV_LIMIT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // process values per slot (4 value bytes, quality, limit)
    input wire logic [NSLOT*32-1:0] slot_value,
    input wire logic [NSLOT*4-1:0] slot_qual,
    input wire logic [NSLOT*2-1:0] slot_limit,
    // cyclic input frame, byte stream to the master
    input wire logic frame_start,
    output logic in_valid,
    output logic [7:0] in_byte,
    output logic in_last,
    input wire logic in_ready,
    // cyclic output bytes from the master, tagged with slot
    input wire logic out_valid,
    input wire logic [3:0] out_slot,
    input wire logic [7:0] out_byte,
    output logic [7:0] ctrl_byte,
    // acyclic request from the link layer
    input wire logic acyc_valid,
    input wire logic [7:0] acyc_sap,
    input wire logic acyc_write,
    input wire logic [7:0] acyc_slot,
    input wire logic [7:0] acyc_index,
    output logic acyc_accept,
    output logic acyc_reject,
    // nonvolatile store write port
    output logic nv_we,
    output logic [7:0] nv_slot,
    output logic [7:0] nv_index,
    // interrupt
    output logic irq
);
    typedef struct packed {
        fss_pkg::fss_state_t st;
        logic [31:0] cfg;
        logic [31:0] act_cfg;
        logic [3:0] slot;
        logic [2:0] bidx;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [31:0] nv_count;
        logic [7:0] ctrl;
        logic [6:0] flen;
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [31:0] rdata;
        logic we;
        logic [7:0] nslot;
        logic [7:0] nidx;
        logic acc;
        logic rej;
    } fss_state_s_t;

    fss_state_s_t s_r, s_nxt;

    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    // slot type of configured slot k, from active configuration
    function automatic fss_pkg::fss_slot_t slot_type(input logic [31:0] c,
                                                     input logic [3:0] k);
        logic [4:0] p;
        p = {k, 1'b0};
        return fss_pkg::fss_slot_t'(c[p +: 2]);
    endfunction

    // status byte: base code plus limit qualifier
    function automatic logic [7:0] status_code(input logic [3:0] q,
                                               input logic [1:0] lim);
        logic [7:0] b;
        b = 8'h00;
        case (fss_pkg::fss_qual_t'(q))
            fss_pkg::FSS_Q_GOOD_OK: b = 8'h80;
            fss_pkg::FSS_Q_GOOD_PARAM: b = 8'h84;
            fss_pkg::FSS_Q_GOOD_WARN: b = 8'h88;
            fss_pkg::FSS_Q_GOOD_ALARM: b = 8'h8C;
            fss_pkg::FSS_Q_UNC: b = 8'h40;
            fss_pkg::FSS_Q_UNC_LAST: b = 8'h44;
            fss_pkg::FSS_Q_UNC_SUBST: b = 8'h48;
            fss_pkg::FSS_Q_UNC_NOSAVE: b = 8'h4C;
            fss_pkg::FSS_Q_UNC_INACC: b = 8'h50;
            fss_pkg::FSS_Q_UNC_MANUAL: b = 8'h60;
            fss_pkg::FSS_Q_BAD_NOFB: b = 8'h08;
            fss_pkg::FSS_Q_BAD_DEV: b = 8'h0C;
            fss_pkg::FSS_Q_BAD_SENSOR: b = 8'h10;
            fss_pkg::FSS_Q_BAD_NOCOMM: b = 8'h18;
            default: b = 8'h1C;
        endcase
        // limit in two low bits; no comm code never carries it, sensor codes have no constant case
        if (q != fss_pkg::FSS_Q_BAD_NOCOMM &&
            !(q == fss_pkg::FSS_Q_BAD_SENSOR && lim == 2'h3)) begin
            b = b | {6'h00, lim};
        end
        return b;
    endfunction

    // --------------------------------------------------
    // ahb-lite data phase and framer state
    // --------------------------------------------------
    logic [31:0] val_w;
    logic [3:0] irq_set;
    logic cur_in;
    logic [4:0] vbit;
    logic [3:0] last_w;
    logic [6:0] len_w;

    // record value of the slot currently being framed
    assign val_w = slot_value[{s_r.slot, 5'h00} +: 32];

    // last input slot ends the frame; trailing empties add nothing
    always_comb begin
        last_w = 4'h0;
        len_w = 7'h00;
        for (int k = 0; k < NSLOT; k++) begin
            if (slot_type(s_r.act_cfg, 4'(k)) == fss_pkg::FSS_SLOT_AI ||
                slot_type(s_r.act_cfg, 4'(k)) == fss_pkg::FSS_SLOT_TOT) begin
                last_w = 4'(k);
                len_w = len_w + 7'(`FSS_REC_BYTES);
            end
        end
    end

    // analog and totalizer slots carry input bytes
    assign cur_in = slot_type(s_r.act_cfg, s_r.slot) == fss_pkg::FSS_SLOT_AI
        || slot_type(s_r.act_cfg, s_r.slot) == fss_pkg::FSS_SLOT_TOT;
    assign vbit = {2'(2'h3 - s_r.bidx[1:0]), 3'h0};

    always_comb begin
        s_nxt = s_r;
        irq_set = 4'h0;
        s_nxt.we = 1'b0;
        s_nxt.acc = 1'b0;
        s_nxt.rej = 1'b0;
        // bus data phase: write lands, read data was latched
        if (s_r.wr) begin
            if (s_r.addr == `FSS_OFS_SLOT_CFG) begin
                s_nxt.cfg = hwdata;
                irq_set[`FSS_IRQ_CFG] = 1'b1;
            end else if (s_r.addr == `FSS_OFS_IRQ_EN) begin
                s_nxt.irq_en = hwdata[3:0];
            end
        end
        s_nxt.wr = 1'b0;
        s_nxt.rd = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_nxt.addr = haddr;
            s_nxt.wr = hwrite;
            s_nxt.rd = !hwrite;
            s_nxt.rdata = 32'h0000_0000;
            if (haddr == `FSS_OFS_SLOT_CFG) begin
                s_nxt.rdata = s_r.cfg;
            end else if (haddr == `FSS_OFS_STATUS) begin
                s_nxt.rdata = {28'h0, s_r.slot[1:0], s_r.st};
            end else if (haddr == `FSS_OFS_IRQ_STAT) begin
                s_nxt.rdata = {28'h0, s_r.irq_stat};
            end else if (haddr == `FSS_OFS_IRQ_EN) begin
                s_nxt.rdata = {28'h0, s_r.irq_en};
            end else if (haddr == `FSS_OFS_NV_COUNT) begin
                s_nxt.rdata = s_r.nv_count;
            end else if (haddr == `FSS_OFS_CTRL_BYTE) begin
                s_nxt.rdata = {24'h0, s_r.ctrl};
            end else if (haddr == `FSS_OFS_FRAME_LEN) begin
                s_nxt.rdata = {25'h0, s_r.flen};
            end
        end
        // frame walks slots 1..9 in fixed order
        case (s_r.st)
            fss_pkg::FSS_ST_IDLE: begin
                if (frame_start) begin
                    s_nxt.st = fss_pkg::FSS_ST_RUN;
                    s_nxt.slot = 4'h0;
                    s_nxt.bidx = 3'h0;
                end
            end
            fss_pkg::FSS_ST_RUN: begin
                if (!cur_in) begin
                    s_nxt.slot = s_r.slot + 4'h1;
                end else if (in_ready) begin
                    // five bytes per record, then next slot
                    if (s_r.bidx == 3'(`FSS_REC_BYTES - 1)) begin
                        s_nxt.bidx = 3'h0;
                        s_nxt.slot = s_r.slot + 4'h1;
                    end else begin
                        s_nxt.bidx = s_r.bidx + 3'h1;
                    end
                end
                // stop after the last input record is taken
                if (s_nxt.slot == 4'(NSLOT) || (in_last && in_ready)) begin
                    s_nxt.st = fss_pkg::FSS_ST_DONE;
                end
            end
            default: begin
                s_nxt.st = fss_pkg::FSS_ST_IDLE;
            end
        endcase
        // control slot takes its single output byte
        // bytes for any other slot type are dropped
        if (out_valid && out_slot != 4'h0 && out_slot <= 4'(NSLOT) &&
            slot_type(s_r.act_cfg, 4'(out_slot - 4'h1)) ==
            fss_pkg::FSS_SLOT_CTRL) begin
            s_nxt.ctrl = out_byte;
            irq_set[`FSS_IRQ_CTRL] = 1'b1;
        end
        // acyclic service runs beside the framer untouched
        if (acyc_valid) begin
            // two class 2 points; class 1 on 33h
            if ((acyc_sap == `FSS_SAP_CLASS1 || acyc_sap == 8'h31 ||
                 acyc_sap == 8'h32) && acyc_slot <= 8'(NSLOT)) begin
                s_nxt.acc = 1'b1;
                // each accepted write goes to the nv store
                if (acyc_write) begin
                    s_nxt.we = 1'b1;
                    s_nxt.nslot = acyc_slot;
                    s_nxt.nidx = acyc_index;
                    s_nxt.nv_count = s_r.nv_count + 32'h1;
                    irq_set[`FSS_IRQ_NVWR] = 1'b1;
                    if (s_r.nv_count + 32'h1 >= NV_LIMIT) begin
                        irq_set[`FSS_IRQ_NVLIM] = 1'b1;
                    end
                end
            end else begin
                s_nxt.rej = 1'b1;
            end
        end
        // sticky events, a set in the clear cycle wins
        if (s_r.wr && s_r.addr == `FSS_OFS_IRQ_CLR) begin
            s_nxt.irq_stat = s_r.irq_stat & ~hwdata[3:0];
        end
        s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
        s_nxt.flen = len_w;
    end

    // --------------------------------------------------
    // state register
    // --------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s_r <= '0;
            // new configuration becomes active only through reset
            s_r.act_cfg <= s_r.cfg;
            s_r.cfg <= s_r.cfg;
            s_r.irq_en <= `FSS_IRQ_EN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // --------------------------------------------------
    // outputs
    // --------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign in_valid = s_r.st == fss_pkg::FSS_ST_RUN && cur_in;
    // four value bytes msb first, then status byte
    assign in_byte = s_r.bidx == 3'h4 ?
        status_code(slot_qual[{s_r.slot, 2'h0} +: 4],
                    slot_limit[{s_r.slot, 1'b0} +: 2]) :
        val_w[vbit +: 8];
    assign in_last = in_valid && s_r.bidx == 3'h4 &&
        s_r.slot == last_w;
    assign ctrl_byte = s_r.ctrl;
    assign acyc_accept = s_r.acc;
    assign acyc_reject = s_r.rej;
    assign nv_we = s_r.we;
    assign nv_slot = s_r.nslot;
    assign nv_index = s_r.nidx;
    assign irq = |(s_r.irq_stat & s_r.irq_en);

    // --------------------------------------------------
    // checks
    // --------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    good_base_a: assert property (
        in_valid && s_r.bidx == 3'h4 &&
        slot_qual[{s_r.slot, 2'h0} +: 4] == 4'h0 |-> in_byte[7:2] == 6'h20)
        else $error("good ok status base wrong");
    limit_bits_a: assert property (
        in_valid && s_r.bidx == 3'h4 &&
        slot_qual[{s_r.slot, 2'h0} +: 4] == 4'h4 |->
        in_byte[1:0] == slot_limit[{s_r.slot, 1'b0} +: 2])
        else $error("limit qualifier not in low bits");
    bad_oos_a: assert property (
        in_valid && s_r.bidx == 3'h4 &&
        slot_qual[{s_r.slot, 2'h0} +: 4] == 4'hE |-> in_byte[7:2] == 6'h07)
        else $error("out of service code wrong");
    unc_subst_a: assert property (
        in_valid && s_r.bidx == 3'h4 &&
        slot_qual[{s_r.slot, 2'h0} +: 4] == 4'h6 |-> in_byte[7:2] == 6'h12)
        else $error("substitute code wrong");
    unc_manual_a: assert property (
        in_valid && s_r.bidx == 3'h4 &&
        slot_qual[{s_r.slot, 2'h0} +: 4] == 4'h9 |-> in_byte[7:2] == 6'h18)
        else $error("manual code wrong");
    record_len_a: assert property (
        in_valid && in_ready && s_r.bidx == 3'h4 |=> s_r.bidx == 3'h0)
        else $error("record not five bytes");
    nv_commit_a: assert property (
        acyc_valid && acyc_write && acyc_sap == 8'h33 &&
        acyc_slot <= 8'(NSLOT) |=> nv_we && nv_index == $past(acyc_index))
        else $error("acyclic write not committed");
    sap_accept_a: assert property (
        acyc_valid && acyc_sap == 8'h33 && acyc_slot <= 8'(NSLOT)
        |=> acyc_accept && !acyc_reject)
        else $error("class 1 access point refused");
    ctrl_ignore_a: assert property (
        out_valid && out_slot != 4'h0 && out_slot <= 4'(NSLOT) &&
        slot_type(s_r.act_cfg, 4'(out_slot - 4'h1)) !=
        fss_pkg::FSS_SLOT_CTRL |=> ctrl_byte == $past(ctrl_byte))
        else $error("output byte to non control slot used");
    cfg_hold_a: assert property (
        s_r.st != fss_pkg::FSS_ST_IDLE |=> $stable(s_r.act_cfg))
        else $error("active configuration changed without reset");

    frame_done_c: cover property (in_last);
    ctrl_write_c: cover property (ctrl_byte != $past(ctrl_byte));
    acyc_write_c: cover property (nv_we);
    irq_c: cover property (irq);
endmodule
`default_nettype wire

// file: bench/fss_master_model.sv
// cyclic master model: frame sink, output byte source, acyclic requester
`default_nettype none
module fss_master_model (
    // clock
    input wire logic mclk,
    // input frame from the device
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_last,
    output logic in_ready,
    // cyclic output bytes to the device
    output logic out_valid,
    output logic [3:0] out_slot,
    output logic [7:0] out_byte,
    // acyclic request
    output logic acyc_valid,
    output logic [7:0] acyc_sap,
    output logic acyc_write,
    output logic [7:0] acyc_slot,
    output logic [7:0] acyc_index
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    int last_pos;
    int last_cnt;
    bit stall_en;
    bit frame_done;
    // idle values at time zero
    initial begin
        {in_ready, out_valid, acyc_valid, acyc_write} = 4'h0;
        {out_slot, out_byte, acyc_sap, acyc_slot, acyc_index} = 36'h0;
        {stall_en, frame_done, last_pos, last_cnt} = 0;
    end
    // collect accepted bytes; random stalls exercise back pressure
    always @(posedge mclk) begin
        if (in_valid && in_ready) begin
            got_q.push_back(in_byte);
            if (in_last) begin
                last_pos = got_q.size() - 1;
                last_cnt++;
                frame_done = 1'b1;
            end
        end
        in_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
    end
    task send_out(input logic [3:0] sl, input logic [7:0] b);
        @(posedge mclk);
        out_valid <= 1'b1;
        out_slot <= sl;
        out_byte <= b;
        @(posedge mclk);
        out_valid <= 1'b0;
        out_slot <= ~sl;
        out_byte <= ~b;
    endtask
    task acyc(input logic [7:0] sap, input logic wr, input logic [7:0] sl,
              input logic [7:0] ix);
        @(posedge mclk);
        acyc_valid <= 1'b1;
        acyc_sap <= sap;
        acyc_write <= wr;
        acyc_slot <= sl;
        acyc_index <= ix;
        @(posedge mclk);
        acyc_valid <= 1'b0;
        acyc_sap <= ~sap;
        acyc_write <= ~wr;
        acyc_slot <= ~sl;
        acyc_index <= ~ix;
    endtask
endmodule
`default_nettype wire

// file: bench/tb_fieldbus_slot_status_framer.sv
// self-checking bench for the fieldbus slot status framer
`include "fss_regs.svh"
`default_nettype none
module tb_fieldbus_slot_status_framer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CFG_A = 32'h0003_0201;
    localparam logic [31:0] CFG_B = 32'h0003_0A55;
    localparam logic [31:0] CFG_C = 32'h0000_0005;
    logic mclk, reset_n, hsel, hwrite, frame_start, hreadyout, hresp;
    logic in_valid, in_last, in_ready, out_valid, acyc_valid, acyc_write;
    logic acyc_accept, acyc_reject, nv_we, irq;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, nv0;
    logic [287:0] slot_value;
    logic [35:0] slot_qual;
    logic [17:0] slot_limit;
    logic [7:0] in_byte, out_byte, ctrl_byte, acyc_sap, acyc_slot;
    logic [7:0] acyc_index, nv_slot, nv_index;
    logic [3:0] out_slot;
    int fails, cmp_count, cycles, combo, nvw;
    logic [7:0] base_tab [15] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h40, 8'h44,
        8'h48, 8'h4C, 8'h50, 8'h60, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
    logic [7:0] saps [5] = '{8'h33, 8'h31, 8'h32, 8'h30, 8'h34};

    // ------------------------------------------------------------
    // design and far-side model
    // ------------------------------------------------------------
    fss_framer #(.NSLOT(9), .NV_LIMIT(32'h0000_0004)) dut (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .slot_value(slot_value), .slot_qual(slot_qual),
        .slot_limit(slot_limit), .frame_start(frame_start),
        .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last),
        .in_ready(in_ready), .out_valid(out_valid), .out_slot(out_slot),
        .out_byte(out_byte), .ctrl_byte(ctrl_byte), .acyc_valid(acyc_valid),
        .acyc_sap(acyc_sap), .acyc_write(acyc_write), .acyc_slot(acyc_slot),
        .acyc_index(acyc_index), .acyc_accept(acyc_accept),
        .acyc_reject(acyc_reject), .nv_we(nv_we), .nv_slot(nv_slot),
        .nv_index(nv_index), .irq(irq));
    fss_master_model pm (
        .mclk(mclk), .in_valid(in_valid), .in_byte(in_byte),
        .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
        .out_slot(out_slot), .out_byte(out_byte), .acyc_valid(acyc_valid),
        .acyc_sap(acyc_sap), .acyc_write(acyc_write), .acyc_slot(acyc_slot),
        .acyc_index(acyc_index));

    // ------------------------------------------------------------
    // clock, hang guard, reporting
    // ------------------------------------------------------------
    always #2.5 mclk = ~mclk;
    // cut a hang short well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    task final_report;
        $display("mismatches %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // bus, reset, frame and acyclic helpers
    // ------------------------------------------------------------
    // single word transfer; waits on hready in both phases
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            @(posedge mclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            @(posedge mclk);
        end
        rd = hrdata;
    endtask
    task reboot;
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    // one frame; quality and limit walk through every combination
    task automatic frame(input logic [31:0] cfg);
        logic [31:0] v;
        logic [7:0] exp_q[$];
        int q, l, n;
        @(posedge mclk);
        for (int s = 0; s < 9; s++) begin
            v = $urandom;
            q = combo % 15;
            l = (combo / 15) % 4;
            slot_value[s*32 +: 32] <= v;
            slot_qual[s*4 +: 4] <= 4'(q);
            slot_limit[s*2 +: 2] <= 2'(l);
            if (cfg[s*2 +: 2] inside {2'h1, 2'h2}) begin
                combo++;
                for (int b = 3; b >= 0; b--) exp_q.push_back(v[b*8 +: 8]);
                exp_q.push_back((q == 13 || (q == 12 && l == 3)) ?
                    base_tab[q] : base_tab[q] | 8'(l));
            end
        end
        pm.got_q.delete();
        pm.frame_done = 1'b0;
        pm.last_cnt = 0;
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        n = 0;
        while (!pm.frame_done && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check(32'(pm.got_q.size()), 32'(exp_q.size()));
        check(32'(pm.last_pos), 32'(exp_q.size() - 1));
        check(32'(pm.last_cnt), 32'h0000_0001);
        foreach (exp_q[i]) begin
            if (i % 5 == 4) begin
                check(32'(pm.got_q[i]), 32'(exp_q[i]));
            end else begin
                check(32'(pm.got_q[i]), 32'(exp_q[i]));
            end
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic acyc_chk(input logic [7:0] sap, input logic wr,
                            input logic [7:0] sl, input logic [7:0] ix);
        logic ok;
        ok = (sap inside {8'h31, 8'h32, 8'h33}) && sl <= 8'h09;
        pm.acyc(sap, wr, sl, ix);
        #1;
        check(32'(acyc_accept), 32'(ok));
        check(32'(acyc_reject), 32'(!ok));
        check(32'(nv_we), 32'(ok && wr));
        if (ok && wr) begin
            nvw++;
            check(32'({nv_slot, nv_index}), 32'({sl, ix}));
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {mclk, reset_n, hsel, hwrite, frame_start} = 5'h00;
        {haddr, htrans, hwdata} = 46'h0;
        hsize = 3'h2;
        {slot_value, slot_qual, slot_limit} = 342'h0;
        {fails, cmp_count, cycles, nvw} = 0;
        combo = $urandom(32'h6d4482cd);
        combo = 0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        ahb(1'b1, `FSS_OFS_SLOT_CFG, CFG_A);
        reboot();
        ahb(1'b0, `FSS_OFS_SLOT_CFG, 32'h0);
        check(rd, CFG_A);
        ahb(1'b0, `FSS_OFS_FRAME_LEN, 32'h0);
        check(rd, 32'h0000_000A);
        ahb(1'b0, `FSS_OFS_NV_COUNT, 32'h0);
        nv0 = rd;
        ahb(1'b1, 12'h040, 32'hFFFF_FFFF);
        ahb(1'b0, 12'h040, 32'h0);
        check(rd, 32'h0000_0000);
        repeat (29) frame(CFG_A);
        fork
            frame(CFG_A);
            begin
                repeat (4) @(posedge mclk);
                acyc_chk(8'h33, 1'b1, 8'h05, 8'h2A);
            end
        join
        pm.send_out(4'h9, 8'hA5);
        #1;
        check(32'(ctrl_byte), 32'h0000_00A5);
        pm.send_out(4'h1, 8'h3C);
        pm.send_out(4'h2, 8'hC3);
        #1;
        check(32'(ctrl_byte), 32'h0000_00A5);
        ahb(1'b0, `FSS_OFS_CTRL_BYTE, 32'h0);
        check(rd, 32'h0000_00A5);
        for (int i = 0; i < 10; i++) begin
            acyc_chk(saps[i % 5], 1'(i % 3 != 1), 8'(10 - i), 8'(i * 17));
        end
        // interrupt: raise, mask, unmask, clear
        ahb(1'b1, `FSS_OFS_IRQ_CLR, 32'h0000_000F);
        ahb(1'b1, `FSS_OFS_IRQ_EN, 32'h0000_0004);
        acyc_chk(8'h33, 1'b1, 8'h03, 8'h07);
        ahb(1'b0, `FSS_OFS_IRQ_STAT, 32'h0);
        check(32'(rd[2]), 32'h1);
        check(32'(irq), 32'h1);
        ahb(1'b1, `FSS_OFS_IRQ_EN, 32'h0);
        #1;
        check(32'(irq), 32'h0);
        ahb(1'b1, `FSS_OFS_IRQ_EN, 32'h0000_0004);
        ahb(1'b1, `FSS_OFS_IRQ_CLR, 32'h0000_0004);
        #1;
        check(32'(irq), 32'h0);
        ahb(1'b0, `FSS_OFS_NV_COUNT, 32'h0);
        check(rd, nv0 + 32'(nvw));
        ahb(1'b0, `FSS_OFS_IRQ_STAT, 32'h0);
        check(32'(rd[3:2]), {30'h0, 1'(nv0 + nvw >= 4), 1'b0});
        // new layout must wait for a reset
        ahb(1'b1, `FSS_OFS_SLOT_CFG, CFG_B);
        frame(CFG_A);
        reboot();
        pm.stall_en = 1'b1;
        repeat (3) frame(CFG_B);
        pm.stall_en = 1'b0;
        ahb(1'b1, `FSS_OFS_SLOT_CFG, CFG_C);
        reboot();
        repeat (2) frame(CFG_C);
        pm.send_out(4'h9, 8'h5A);
        #1;
        check(32'(ctrl_byte), 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire
